/* liu_capture_pkg.sv */
// constants for the receive line capture and transmit input clock block
package liu_capture_pkg;

  // ==========================================================
  // register bus geometry
  localparam int addr_w = 5;
  localparam int data_w = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] mode_control_one_addr = 5'h00;
  localparam logic [4:0] mode_control_three_addr = 5'h04;
  localparam logic [4:0] mode_control_five_addr = 5'h08;
  localparam logic [4:0] violation_count_low_addr = 5'h0C;
  localparam logic [4:0] violation_count_high_addr = 5'h10;
  localparam logic [4:0] irq_status_addr = 5'h14;
  localparam logic [4:0] irq_mask_addr = 5'h18;
  localparam logic [4:0] line_status_addr = 5'h1C;

  // ==========================================================
  // field positions
  localparam int binary_if_select_bit = 0;
  localparam int tx_input_clock_invert_bit = 0;
  localparam int rx_clock_edge_invert_bit = 0;
  localparam int rx_positive_invert_bit = 1;
  localparam int rx_negative_invert_bit = 2;
  localparam int irq_violation_bit = 0;
  localparam int irq_saturate_bit = 1;
  localparam int irq_frame_bit = 2;
  localparam int line_pos_bit = 0;
  localparam int line_neg_bit = 1;
  localparam int line_common_bit = 2;

  // ==========================================================
  // reset values and widths
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam int count_w = 16;
  localparam logic [15:0] count_max = 16'hFFFF;

  // ==========================================================
  // response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_decerr = 2'h3;

endpackage

/* link_sample_if.sv */
// carrier between a link clock sampler and the logic that configures it
`timescale 1ns/1ps
interface link_sample_if
#(
  parameter int width = 2
)
();
  logic edge_invert;
  logic strobe;
  logic [width-1:0] data;

  modport sampler
  (
    input edge_invert,
    output strobe,
    output data
  );
  modport user
  (
    output edge_invert,
    input strobe,
    input data
  );
endinterface

/* link_edge_sampler.sv */
// synchronises a link clock and its data pins, captures on the chosen edge
`timescale 1ns/1ps
module link_edge_sampler
  import liu_capture_pkg::*;
#(
  parameter int width = 2
)
(
  input logic mclk_i,
  input logic reset_n_i,
  input logic link_clock_i,
  input logic [width-1:0] link_data_i,
  link_sample_if.sampler bus
);

  // ==========================================================
  // elaboration check
  generate
    if (width < 1)
    begin : g_bad_width
      $error("link_edge_sampler needs at least one data pin");
    end
  endgenerate

  // ==========================================================
  // state
  typedef struct packed {
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic [width-1:0] data_meta;
    logic [width-1:0] data_sync;
    logic strobe;
    logic [width-1:0] data;
  } sampler_state_type;

  sampler_state_type s_q;
  sampler_state_type s_d;
  logic rise;
  logic fall;

  // edges seen only on the second synchroniser stage
  assign rise = s_q.clk_sync & ~s_q.clk_prev;
  assign fall = ~s_q.clk_sync & s_q.clk_prev;

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.clk_meta = link_clock_i;
    s_d.clk_sync = s_q.clk_meta;
    s_d.clk_prev = s_q.clk_sync;
    s_d.data_meta = link_data_i;
    s_d.data_sync = s_q.data_meta;
    s_d.strobe = 1'b0;
    if (bus.edge_invert ? fall : rise)
    begin
      s_d.strobe = 1'b1;
      s_d.data = s_q.data_sync; // same delay as the clock path
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bus.strobe = s_q.strobe;
  assign bus.data = s_q.data;

endmodule

/* liu_rx_capture_and_tx_clock_in.sv */
// receive line capture and transmit input clock sampling for one channel
//
// Summary of operation
// - binary select 0: inputs are positive and negative AMI rails.
// - binary select 1: data on positive pin, violations on negative pin.
// - in binary mode a high data level is a one, low a zero.
// - receive inputs taken on rising clock edge, falling when invert set.
// - positive invert flips positive rail or binary data first.
// - negative invert flips negative rail or violation input first.
// - binary mode counts clock cycles with active violation input.
// - works with continuous or gapped receive line clock.
// - transmit inputs are all sampled with the transmit input clock.
// - continuous or gapped transmit input clock accepted.
// - transmit inputs taken on rising edge, falling when invert set.
// - common clock select high ignores the channel transmit clock.
`timescale 1ns/1ps
module liu_rx_capture_and_tx_clock_in
  import liu_capture_pkg::*;
(
  input logic mclk_i,
  input logic reset_n_i,
  // register bus
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [addr_w-1:0] s_axi_awaddr,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [data_w-1:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [addr_w-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [data_w-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic irq_o,
  // receive line pins
  input logic rx_line_clock_i,
  input logic rx_positive_rail_i,
  input logic rx_negative_rail_i,
  // transmit system pins
  input logic tx_input_clock_i,
  input logic common_tx_clock_i,
  input logic common_tx_clock_select_i,
  input logic tx_payload_in_i,
  input logic tx_payload_enable_i,
  input logic tx_frame_marker_i,
  input logic tx_overwrite_data_i,
  input logic tx_overwrite_enable_i,
  // receive stream out
  output logic rx_strobe_o,
  output logic rx_positive_rail_o,
  output logic rx_negative_rail_o,
  output logic rx_binary_data_o,
  output logic rx_violation_flag_o,
  // transmit samples out
  output logic tx_strobe_o,
  output logic tx_payload_o,
  output logic tx_payload_enable_o,
  output logic tx_frame_marker_o,
  output logic tx_overwrite_data_o,
  output logic tx_overwrite_enable_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] mode_control_one;
    logic [7:0] mode_control_three;
    logic [7:0] mode_control_five;
    logic [7:0] irq_mask;
    logic [7:0] irq_status;
    logic [count_w-1:0] count;
    logic [7:0] count_high_shadow;
    logic common_sel_meta;
    logic common_sel_sync;
    logic rx_strobe;
    logic rx_pos;
    logic rx_neg;
    logic rx_data_bit;
    logic rx_viol;
    logic tx_strobe;
    logic [4:0] tx_sample;
    logic aw_held;
    logic [addr_w-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [data_w-1:0] rdata;
    logic [1:0] rresp;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;
  logic tx_clock_pin;
  logic pos_in;
  logic neg_in;
  logic binary_mode;
  logic aw_take;
  logic w_take;
  logic ar_take;

  link_sample_if #(.width(2)) rx_bus ();
  link_sample_if #(.width(5)) tx_bus ();

  // ==========================================================
  // address decode shared by reads and writes
  function automatic logic addr_mapped(input logic [addr_w-1:0] a);
    addr_mapped = (a == mode_control_one_addr) ||
      (a == mode_control_three_addr) || (a == mode_control_five_addr) ||
      (a == violation_count_low_addr) ||
      (a == violation_count_high_addr) || (a == irq_status_addr) ||
      (a == irq_mask_addr) || (a == line_status_addr);
  endfunction

  // ==========================================================
  // link samplers
  // common clock bypass
  assign tx_clock_pin = s_q.common_sel_sync ? common_tx_clock_i :
    tx_input_clock_i;

  assign rx_bus.edge_invert = s_q.mode_control_five[rx_clock_edge_invert_bit];
  assign tx_bus.edge_invert =
    s_q.mode_control_three[tx_input_clock_invert_bit];

  // receive clock edges found by oversampling
  link_edge_sampler #(.width(2)) rx_sampler
  (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .link_clock_i(rx_line_clock_i),
    .link_data_i({rx_negative_rail_i, rx_positive_rail_i}),
    .bus(rx_bus.sampler)
  );

  // all transmit inputs on one clock, gaps tolerated
  link_edge_sampler #(.width(5)) tx_sampler
  (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .link_clock_i(tx_clock_pin),
    .link_data_i({tx_overwrite_enable_i, tx_overwrite_data_i,
      tx_frame_marker_i, tx_payload_enable_i, tx_payload_in_i}),
    .bus(tx_bus.sampler)
  );

  // ==========================================================
  // input polarity and mode
  assign binary_mode = s_q.mode_control_one[binary_if_select_bit];
  assign pos_in = rx_bus.data[0] ^
    s_q.mode_control_five[rx_positive_invert_bit];
  assign neg_in = rx_bus.data[1] ^
    s_q.mode_control_five[rx_negative_invert_bit];

  // bus handshakes, one write and one read at a time
  assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
  assign s_axi_wready = ~s_q.w_held & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.common_sel_meta = common_tx_clock_select_i;
    s_d.common_sel_sync = s_q.common_sel_meta;
    s_d.rx_strobe = 1'b0;
    s_d.tx_strobe = 1'b0;

    // write channel capture in either order
    if (aw_take)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      s_d.w_held = 1'b1;
      s_d.w_byte = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // register write once address and data are both held
    if (s_d.aw_held && s_d.w_held && !s_q.bvalid)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_mapped(s_d.aw_addr) ? resp_okay : resp_decerr;
      if (s_d.w_lane0)
      begin
        unique case (s_d.aw_addr)
          mode_control_one_addr: s_d.mode_control_one = s_d.w_byte;
          mode_control_three_addr: s_d.mode_control_three = s_d.w_byte;
          mode_control_five_addr: s_d.mode_control_five = s_d.w_byte;
          irq_mask_addr: s_d.irq_mask = s_d.w_byte;
          violation_count_low_addr: s_d.count = '0; // clears the count
          default: s_d.rdata = s_d.rdata; // read-only or unmapped
        endcase
      end
    end

    // register read, status cleared by reading it
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = '0;
      s_d.rresp = addr_mapped(s_axi_araddr) ? resp_okay : resp_decerr;
      unique case (s_axi_araddr)
        mode_control_one_addr: s_d.rdata[7:0] = s_q.mode_control_one;
        mode_control_three_addr: s_d.rdata[7:0] = s_q.mode_control_three;
        mode_control_five_addr: s_d.rdata[7:0] = s_q.mode_control_five;
        violation_count_low_addr:
        begin
          s_d.rdata[7:0] = s_q.count[7:0];
          s_d.count_high_shadow = s_q.count[15:8];
        end
        violation_count_high_addr: s_d.rdata[7:0] = s_q.count_high_shadow;
        irq_status_addr:
        begin
          s_d.rdata[7:0] = s_q.irq_status;
          s_d.irq_status = '0;
        end
        irq_mask_addr: s_d.rdata[7:0] = s_q.irq_mask;
        line_status_addr:
        begin
          s_d.rdata[line_pos_bit] = s_q.rx_pos | s_q.rx_data_bit;
          s_d.rdata[line_neg_bit] = s_q.rx_neg | s_q.rx_viol;
          s_d.rdata[line_common_bit] = s_q.common_sel_sync;
        end
        default: s_d.rdata = '0;
      endcase
    end

    // receive capture, after the read so that events win
    if (rx_bus.strobe)
    begin
      s_d.rx_strobe = 1'b1;
      if (binary_mode)
      begin
        s_d.rx_data_bit = pos_in;
        s_d.rx_viol = neg_in;
        s_d.rx_pos = 1'b0;
        s_d.rx_neg = 1'b0;
        if (neg_in)
        begin
          s_d.irq_status[irq_violation_bit] = 1'b1;
          if (s_d.count != count_max)
            s_d.count = s_d.count + 16'h0001;
          if (s_d.count == count_max)
            s_d.irq_status[irq_saturate_bit] = 1'b1;
        end
      end
      else
      begin
        s_d.rx_pos = pos_in;
        s_d.rx_neg = neg_in;
        s_d.rx_data_bit = 1'b0;
        s_d.rx_viol = 1'b0;
      end
    end

    // transmit sample, frame marker raises an event
    if (tx_bus.strobe)
    begin
      s_d.tx_strobe = 1'b1;
      s_d.tx_sample = tx_bus.data;
      if (tx_bus.data[2])
        s_d.irq_status[irq_frame_bit] = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q <= '0;
      s_q.mode_control_one <= mode_reset;
      s_q.mode_control_three <= mode_reset;
      s_q.mode_control_five <= mode_reset;
      s_q.irq_mask <= mask_reset;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign irq_o = |(s_q.irq_status & s_q.irq_mask);
  assign rx_strobe_o = s_q.rx_strobe;
  assign rx_positive_rail_o = s_q.rx_pos;
  assign rx_negative_rail_o = s_q.rx_neg;
  assign rx_binary_data_o = s_q.rx_data_bit;
  assign rx_violation_flag_o = s_q.rx_viol;
  assign tx_strobe_o = s_q.tx_strobe;
  assign tx_payload_o = s_q.tx_sample[0];
  assign tx_payload_enable_o = s_q.tx_sample[1];
  assign tx_frame_marker_o = s_q.tx_sample[2];
  assign tx_overwrite_data_o = s_q.tx_sample[3];
  assign tx_overwrite_enable_o = s_q.tx_sample[4];

endmodule

/* liu_capture_props.sv */
// port assertions for the receive capture and transmit clock block
`timescale 1ns/1ps
module liu_capture_props
(
  input logic mclk_i,
  input logic reset_n_i,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_bvalid,
  input logic irq_o,
  input logic rx_line_clock_i,
  input logic rx_strobe_o,
  input logic rx_positive_rail_o,
  input logic rx_negative_rail_o,
  input logic rx_binary_data_o,
  input logic rx_violation_flag_o,
  input logic tx_strobe_o,
  input logic tx_payload_o,
  input logic tx_frame_marker_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // link clock edge age
  logic clk_q;
  logic [3:0] age_q;
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      clk_q <= 1'b0;
      age_q <= 4'hF;
    end
    else
    begin
      clk_q <= rx_line_clock_i;
      if (rx_line_clock_i != clk_q)
        age_q <= 4'h0;
      else if (age_q != 4'hF)
        age_q <= age_q + 4'h1;
    end

  // ==========================================================
  // receive and transmit sides
  // strobe tied to edge
  rx_edge_age_a: assert property (rx_strobe_o |-> age_q inside {[2:4]})
    else $error("receive strobe without a link clock edge");
  rx_pulse_a: assert property (rx_strobe_o |=> !rx_strobe_o)
    else $error("receive strobe longer than one cycle");
  rx_hold_a: assert property (
    !rx_strobe_o |-> $stable({rx_positive_rail_o,
    rx_negative_rail_o, rx_binary_data_o, rx_violation_flag_o}))
    else $error("receive outputs moved without strobe");
  rx_mode_a: assert property (
    (rx_binary_data_o || rx_violation_flag_o)
    |-> !(rx_positive_rail_o || rx_negative_rail_o))
    else $error("binary and rail outputs both active");
  tx_hold_a: assert property (
    !tx_strobe_o |-> $stable({tx_payload_o, tx_frame_marker_o}))
    else $error("transmit samples moved without strobe");

  // ==========================================================
  // interrupt and bus
  // irq follows events
  irq_rise_a: assert property (
    $rose(irq_o) |-> rx_strobe_o || tx_strobe_o || $rose(s_axi_bvalid))
    else $error("interrupt rose without a cause");
  irq_fall_a: assert property (
    $fell(irq_o) |-> $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
    else $error("interrupt fell without a read or write");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");

  cover property (rx_strobe_o && rx_binary_data_o);
  cover property (tx_strobe_o && tx_frame_marker_o);
  cover property ($rose(irq_o));
endmodule

bind liu_rx_capture_and_tx_clock_in liu_capture_props i_props (.*);

/* line_model.sv */
// far-side line unit: gapped link clock with its data lines
`timescale 1ns/1ps
module line_model
#(
  parameter int w = 2
)
(
  output logic clk_o,
  output logic [w-1:0] data_o
);
  initial
  begin
    clk_o = 1'b0;
    data_o = '0;
  end

  // one gapped bit of a 160 ns clock, a before rise, b before fall
  // edges on an exact time grid, so the clock carries no jitter
  task automatic send(input logic [w-1:0] a, input logic [w-1:0] b);
    begin
      #7 data_o = a;
      #40 clk_o = 1'b1;
      #40 data_o = b;
      #40 clk_o = 1'b0;
      #40 data_o = ~b;
    end
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the receive capture and transmit clock block
`timescale 1ns/1ps
module testbench;
  import liu_capture_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_o, rx_line_clock_i, tx_input_clock_i;
  logic rx_positive_rail_i, rx_negative_rail_i, tx_payload_in_i;
  logic tx_payload_enable_i, tx_frame_marker_i, tx_overwrite_data_i;
  logic tx_overwrite_enable_i, common_tx_clock_i = 1'b0;
  logic common_tx_clock_select_i = 1'b0;
  logic rx_strobe_o, rx_positive_rail_o, rx_negative_rail_o, tx_payload_o;
  logic rx_binary_data_o, rx_violation_flag_o, tx_strobe_o;
  logic tx_payload_enable_o, tx_frame_marker_o, tx_overwrite_data_o;
  logic tx_overwrite_enable_o;
  logic [3:0] rx_got = 4'h0;
  logic [4:0] tx_got = 5'h00;
  logic [1:0] b_got = 2'h0;
  int rx_n = 0, tx_n = 0, cyc = 0, bad_count = 0, check_count = 0;

  liu_rx_capture_and_tx_clock_in i_liu_rx_capture_and_tx_clock_in (.*);
  line_model #(.w(2)) rx_far (.clk_o(rx_line_clock_i),
    .data_o({rx_negative_rail_i, rx_positive_rail_i}));
  line_model #(.w(5)) tx_far (.clk_o(tx_input_clock_i),
    .data_o({tx_overwrite_enable_i, tx_overwrite_data_i, tx_frame_marker_i,
    tx_payload_enable_i, tx_payload_in_i}));

  always #10 mclk_i = ~mclk_i;

  // record samples, cut a hang short
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (rx_strobe_o)
    begin
      rx_got <= {rx_violation_flag_o, rx_binary_data_o, rx_negative_rail_o,
        rx_positive_rail_o};
      rx_n <= rx_n + 1;
    end
    if (tx_strobe_o)
    begin
      tx_got <= {tx_overwrite_enable_o, tx_overwrite_data_o,
        tx_frame_marker_o, tx_payload_enable_o, tx_payload_o};
      tx_n <= tx_n + 1;
    end
    if (cyc == 30000)
    begin
      bad_count++;
      test_done;
    end
  end

  // ==========================================================
  // checking and bus tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      check_count++;
      if (got !== exp)
      begin
        bad_count++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    logic ad, wdn, ta, tw;
    begin
      ad = 1'b0;
      wdn = 1'b0;
      @(posedge mclk_i);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      while (!(ad && wdn))
      begin
        @(negedge mclk_i);
        ta = s_axi_awready && !ad;
        tw = s_axi_wready && !wdn;
        @(posedge mclk_i);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        ad = ad | ta;
        wdn = wdn | tw;
      end
      do @(negedge mclk_i); while (!s_axi_bvalid);
      b_got = s_axi_bresp;
      @(posedge mclk_i);
      s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    begin
      @(posedge mclk_i);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do @(negedge mclk_i); while (!s_axi_arready);
      @(posedge mclk_i);
      s_axi_arvalid <= 1'b0;
      do @(negedge mclk_i); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk_i);
      s_axi_rready <= 1'b0;
    end
  endtask

  task chk_irq(input logic e);
    begin
      @(negedge mclk_i);
      check({31'h0, irq_o}, {31'h0, e});
    end
  endtask

  // ==========================================================
  // scenarios
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    begin
      for (int i = 0; i < 3; i++)
      begin
        rd(5'(i * 4), d, r);
        check(d, 32'h0);
      end
      wr(mode_control_five_addr, 32'h1FF);
      check({30'h0, b_got}, {30'h0, resp_okay});
      rd(mode_control_five_addr, d, r);
      check(d, 32'hFF);
      wr(5'h02, 32'h0);
      check({30'h0, b_got}, {30'h0, resp_decerr});
      rd(5'h02, d, r);
      check({30'h0, r}, {30'h0, resp_decerr});
    end
  endtask

  task t_rx;
    logic [31:0] d, e;
    logic [1:0] r, c;
    logic p, n;
    int cnt, n0;
    begin
      cnt = 0;
      wr(violation_count_low_addr, 32'h0);
      for (int m = 0; m < 16; m++)
      begin
        wr(mode_control_one_addr, {31'h0, m[3]});
        wr(mode_control_five_addr, {29'h0, m[2:0]});
        n0 = rx_n;
        rx_far.send(2'h1, 2'h2);
        repeat (8) @(posedge mclk_i);
        c = m[0] ? 2'h2 : 2'h1;
        p = c[0] ^ m[1];
        n = c[1] ^ m[2];
        if (m[3]) cnt += n;
        check(32'(rx_n - n0), 32'h1);
        e = m[3] ? {28'h0, n, p, 2'h0} : {30'h0, n, p};
        check({28'h0, rx_got}, e);
      end
      rd(violation_count_low_addr, d, r);
      check(d, 32'(cnt));
      rd(violation_count_high_addr, d, r);
      check(d, 32'h0);
    end
  endtask

  task t_tx;
    logic [31:0] d;
    logic [1:0] r;
    int n0;
    begin
      rd(irq_status_addr, d, r);
      for (int m = 0; m < 2; m++)
      begin
        wr(mode_control_three_addr, 32'(m));
        n0 = tx_n;
        tx_far.send(5'h15, 5'h0A);
        repeat (8) @(posedge mclk_i);
        check(32'(tx_n - n0), 32'h1);
        check({27'h0, tx_got}, m ? 32'h0A : 32'h15);
      end
      rd(irq_status_addr, d, r);
      check(d, 32'h4);
      common_tx_clock_select_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      n0 = tx_n;
      tx_far.send(5'h15, 5'h0A);
      repeat (8) @(posedge mclk_i);
      check(32'(tx_n - n0), 32'h0);
      rd(line_status_addr, d, r);
      check(d & 32'h4, 32'h4);
      // channel clock held low, common clock drives the sampling
      n0 = tx_n;
      common_tx_clock_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      common_tx_clock_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      check(32'(tx_n - n0), 32'h1);
      check({27'h0, tx_got}, 32'h15);
      common_tx_clock_select_i <= 1'b0;
    end
  endtask

  task t_irq;
    logic [31:0] d;
    logic [1:0] r;
    begin
      wr(mode_control_five_addr, 32'h0);
      rd(irq_status_addr, d, r);
      wr(irq_mask_addr, 32'h1);
      rx_far.send(2'h2, 2'h2);
      chk_irq(1'b1);
      rd(irq_status_addr, d, r);
      check(d, 32'h1);
      chk_irq(1'b0);
      wr(irq_mask_addr, 32'h0);
      rx_far.send(2'h2, 2'h2);
      chk_irq(1'b0);
      rd(irq_status_addr, d, r);
      check(d, 32'h1);
    end
  endtask

  // reset, then each scenario in turn
  initial
  begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_regs;
    t_rx;
    t_tx;
    t_irq;
    test_done;
  end
endmodule
